// file: pkg/bpc_regs.svh
// Register map, command codes, parameter encodings and timing constants
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH

// Command staging, status and readback registers
`define BPC_OFS_OPC         16'h0000
`define BPC_OFS_ARG0        16'h0004
`define BPC_OFS_ARG_LAST    16'h001c
`define BPC_OFS_GO          16'h0020
`define BPC_OFS_STATUS      16'h0024
`define BPC_OFS_CARRIER     16'h0028
`define BPC_OFS_OFFSETS     16'h002c
`define BPC_OFS_MODEM       16'h0030
`define BPC_OFS_FRAME       16'h0034
`define BPC_OFS_RATE_HZ     16'h0038

// Byte locations, as word indexes (byte address is four times the index)
`define BPC_IDX_ACCESS_MSB  14'h09cf
`define BPC_IDX_ACCESS_LSB  14'h09d2
`define BPC_IDX_SEED_MSB    14'h09c7
`define BPC_IDX_SEED_LSB    14'h09c9
`define BPC_CFG_BYTES       7
`define BPC_ACCESS_BYTES    3'd4

// Opcodes
`define BPC_OPC_IDLE        8'h01
`define BPC_OPC_FORMAT      8'h02
`define BPC_OPC_CARRIER     8'h03
`define BPC_OPC_OFFSETS     8'h04
`define BPC_OPC_MODEM       8'h05
`define BPC_OPC_FRAME       8'h06

// Parameter encodings
`define BPC_STBY_RC         8'h00
`define BPC_FMT_BLE         8'h04
`define BPC_RATE_1M_BW_1P2  8'h45
`define BPC_MOD_INDEX_HALF  8'h01
`define BPC_SHAPING_BT_HALF 8'h20
`define BPC_LINK_31         8'h00
`define BPC_LINK_37         8'h20
`define BPC_LINK_TEST       8'h40
`define BPC_LINK_255        8'h80
`define BPC_LEN_31          8'd31
`define BPC_LEN_37          8'd37
`define BPC_LEN_63          8'd63
`define BPC_LEN_255         8'd255
`define BPC_CHECK_OFF       8'h00
`define BPC_CHECK_3B        8'h10
`define BPC_SCRAMBLER_ON    8'h00
`define BPC_SCRAMBLER_OFF   8'h08
`define BPC_PAT_PRBS9       8'h00
`define BPC_PAT_EYELONG_10  8'h04
`define BPC_PAT_EYESHORT_10 8'h08
`define BPC_PAT_PRBS15      8'h0c
`define BPC_PAT_ONES        8'h10
`define BPC_PAT_ZEROS_NAMED 8'h14
`define BPC_PAT_EYELONG_01  8'h18
`define BPC_PAT_EYESHORT_01 8'h1c
`define BPC_BYTE_EYELONG_10  8'hf0
`define BPC_BYTE_EYESHORT_10 8'haa
`define BPC_BYTE_ONES        8'hff
`define BPC_BYTE_EYELONG_01  8'h0f
`define BPC_BYTE_EYESHORT_01 8'h55
`define BPC_PRBS9_SEED      9'h1ff
`define BPC_PRBS15_SEED     15'h7fff

// Synthesizer: one step is the reference over two to the eighteenth
`define BPC_FREF_HZ         50'd52000000
`define BPC_PLL_DIV_BITS    18

// Timing
`define BPC_CLK_MHZ         50
`define BPC_CAL_TIME_US     100
`define BPC_CMD_CYCLES      3'd4

`endif

// file: pkg/bpc_pkg.sv
// Types shared by the command interpreter
package bpc_pkg;

	typedef enum logic [1:0] {
		BPC_ST_CAL,
		BPC_ST_IDLE,
		BPC_ST_EXEC
	} bpc_state_t;

	typedef struct packed {
		logic [7:0] rate;
		logic [7:0] index;
		logic [7:0] shaping;
		logic       rate_1m_bw_1p2;
		logic       mod_index_half;
		logic       shaping_bt_half;
	} bpc_modem_cfg_t;

	typedef struct packed {
		logic [7:0] max_payload;
		logic       check_three_bytes;
		logic       scrambler_on;
		logic       transmit_test_state;
		logic [7:0] test_pattern_select;
	} bpc_frame_cfg_t;

endpackage

// file: src/bpc_pattern_gen.sv
// Transmit test payload bit generator
`include "bpc_regs.svh"
module bpc_pattern_gen import bpc_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Control
	input  wire logic       enable,
	input  wire logic [7:0] pattern_sel,
	input  wire logic       restart,
	input  wire logic       bit_take,
	// Serial pattern
	output logic            test_bit
);

	logic [8:0]  lfsr9_q;
	logic [14:0] lfsr15_q;
	logic [2:0]  idx_q;
	wire  logic  fb9;
	wire  logic  fb15;
	wire  logic [7:0] fix_byte;
	wire  logic  cur_bit;

	assign fb9  = lfsr9_q[8] ^ lfsr9_q[4]; // [RL13]
	assign fb15 = lfsr15_q[14] ^ lfsr15_q[13] ^ lfsr15_q[12] ^ lfsr15_q[11]
		^ lfsr15_q[1] ^ lfsr15_q[0]; // [RL14]

	// Bytes go out msb first; the zeros-named code repeats ones as printed
	assign fix_byte =
		(pattern_sel == `BPC_PAT_EYELONG_10)  ? `BPC_BYTE_EYELONG_10  :
		(pattern_sel == `BPC_PAT_EYESHORT_10) ? `BPC_BYTE_EYESHORT_10 :
		(pattern_sel == `BPC_PAT_ONES)        ? `BPC_BYTE_ONES        :
		(pattern_sel == `BPC_PAT_ZEROS_NAMED) ? `BPC_BYTE_ONES        :
		(pattern_sel == `BPC_PAT_EYELONG_01)  ? `BPC_BYTE_EYELONG_01  :
		(pattern_sel == `BPC_PAT_EYESHORT_01) ? `BPC_BYTE_EYESHORT_01 : 8'h00; // [RL15]

	assign cur_bit =
		(pattern_sel == `BPC_PAT_PRBS9)  ? lfsr9_q[8]  :
		(pattern_sel == `BPC_PAT_PRBS15) ? lfsr15_q[14] : fix_byte[idx_q];
	assign test_bit = enable & cur_bit; // [RL16]

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lfsr9_q  <= `BPC_PRBS9_SEED;
			lfsr15_q <= `BPC_PRBS15_SEED;
			idx_q    <= 3'h7;
		end else if (restart) begin
			lfsr9_q  <= `BPC_PRBS9_SEED; // [RL13]
			lfsr15_q <= `BPC_PRBS15_SEED;
			idx_q    <= 3'h7;
		end else if (bit_take) begin
			lfsr9_q  <= {lfsr9_q[7:0], fb9};
			lfsr15_q <= {lfsr15_q[13:0], fb15};
			idx_q    <= idx_q - 3'h1;
		end
	end

	property p_prbs9_ones;
		@(posedge core_clk) disable iff (!rst_b)
		(enable && pattern_sel == `BPC_PAT_PRBS9 && restart) ##1
		(bit_take && !restart && enable)[*8] |-> test_bit;
	endproperty
	a_prbs9_ones: assert property (p_prbs9_ones) else $error("prbs9 lost leading ones"); // [RL13]

	property p_prbs15_shift;
		@(posedge core_clk) disable iff (!rst_b)
		(bit_take && !restart) |=> lfsr15_q[0] == $past(fb15) && lfsr15_q != 15'h0000;
	endproperty
	a_prbs15_shift: assert property (p_prbs15_shift) else $error("prbs15 feedback wrong"); // [RL14]

	property p_eyeshort;
		@(posedge core_clk) disable iff (!rst_b)
		(enable && pattern_sel == `BPC_PAT_EYESHORT_10 && restart) ##1
		(bit_take && !restart && enable) |-> test_bit ##1 !test_bit;
	endproperty
	a_eyeshort: assert property (p_eyeshort) else $error("alternating pattern wrong"); // [RL15]

endmodule // bpc_pattern_gen

// file: src/bpc_cmd_core.sv
// Command interpreter configuring the frame handler and modem for BLE use
// Operation
// RL1: Calibrate after reset, then standby, busy low
// RL2: Host enters standby before configuring
// RL3: Format command selects BLE framing
// RL4: Carrier word step is reference over 2^18
// RL5: Carrier word sets transmit frequency
// RL6: Payload pointers start at programmed offsets
// RL7: Modem bytes: rate, index, shaping; 0x45 accepted
// RL8: Index byte 0x01 means index 0.5
// RL9: Shaping byte 0x20 means SHAPING_BT_HALF
// RL10: Frame command sends seven bytes, last three zero
// RL11: Link state sets maximum payload size
// RL12: Check field off or three bytes
// RL13: Code 0x00 sends PRBS9 starting nine ones
// RL14: Code 0x0C sends PRBS15 sequence
// RL15: Fixed-byte test codes repeat their bytes
// RL16: Test pattern ignored outside transmit test state
// RL17: Whitening on at 0x00, off at 0x08
// RL18: Host disables whitening only in test state
// RL19: Access address bytes, msb first, from 0x9CF
// RL20: Check seed bytes from 0x9C7 to 0x9C9
// RL21: Busy high per command; host waits
//
// Added by the designer: the register offsets and the plain strobed port.
`include "bpc_regs.svh"
module bpc_cmd_core import bpc_pkg::*; #(
	parameter int CAL_CYCLES = `BPC_CAL_TIME_US * `BPC_CLK_MHZ
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Busy pin
	output logic             busy,
	// Configuration
	output logic             rc_oscillator_standby,
	output logic             frame_format_ble,
	output logic      [23:0] carrier_word,
	output logic      [31:0] carrier_hz,
	output logic      [7:0]  transmit_payload_offset,
	output logic      [7:0]  receive_payload_offset,
	output bpc_modem_cfg_t   modem_cfg,
	output bpc_frame_cfg_t   frame_cfg,
	output logic      [31:0] access_addr,
	output logic      [23:0] check_seed,
	output logic             cmd_error,
	// Frame handler side
	input  wire logic        pkt_start,
	input  wire logic        tx_byte_take,
	input  wire logic        rx_byte_put,
	input  wire logic        test_bit_take,
	output logic      [7:0]  tx_buf_addr,
	output logic      [7:0]  rx_buf_addr,
	output logic             test_bit
);

	bpc_state_t  state_q, state_d;
	logic [19:0] cal_cnt_q;
	logic [2:0]  exec_cnt_q;
	logic        busy_q;
	logic [7:0]  opc_q;
	logic [7:0]  arg_q [7];
	logic [7:0]  cfg_q [`BPC_CFG_BYTES];
	logic        fmt_ble_q, err_q;
	logic [23:0] carrier_q;
	logic [31:0] hz_q;
	logic [7:0]  tx_off_q, rx_off_q, tx_ptr_q, rx_ptr_q;
	logic [7:0]  rate_q, index_q, shaping_q;
	logic [7:0]  link_q, check_q, pat_q, wht_q;
	logic [31:0] rdata_q;

	// Address decode
	wire logic [13:0] widx = reg_addr[15:2];
	wire logic        aligned = reg_addr[1:0] == 2'b00;
	wire logic        hit_opc = reg_addr == `BPC_OFS_OPC;
	wire logic        hit_arg = aligned && reg_addr >= `BPC_OFS_ARG0
		&& reg_addr <= `BPC_OFS_ARG_LAST;
	wire logic [2:0]  arg_sel = 3'(widx - `BPC_OFS_ARG0 / 4);
	wire logic        hit_acc = aligned && widx >= `BPC_IDX_ACCESS_MSB
		&& widx <= `BPC_IDX_ACCESS_LSB;
	wire logic        hit_seed = aligned && widx >= `BPC_IDX_SEED_MSB
		&& widx <= `BPC_IDX_SEED_LSB;
	wire logic        hit_cfg = hit_acc || hit_seed;
	wire logic [2:0]  cfg_sel = hit_acc ? 3'(widx - `BPC_IDX_ACCESS_MSB)
		: 3'(widx - `BPC_IDX_SEED_MSB) + `BPC_ACCESS_BYTES;
	wire logic        go_hit = reg_wr && reg_addr == `BPC_OFS_GO;
	// A command issued while busy is dropped, which is why the host polls busy
	wire logic        go_ok = go_hit && state_q == BPC_ST_IDLE; // [RL21]

	// Accepted commands
	wire logic cmd_idle    = go_ok && opc_q == `BPC_OPC_IDLE;
	wire logic cmd_fmt     = go_ok && opc_q == `BPC_OPC_FORMAT;
	wire logic cmd_carrier = go_ok && opc_q == `BPC_OPC_CARRIER;
	wire logic cmd_offsets = go_ok && opc_q == `BPC_OPC_OFFSETS;
	wire logic cmd_modem   = go_ok && opc_q == `BPC_OPC_MODEM;
	wire logic cmd_frame   = go_ok && opc_q == `BPC_OPC_FRAME;
	wire logic cmd_known   = cmd_idle || cmd_fmt || cmd_carrier || cmd_offsets
		|| cmd_modem || cmd_frame;

	wire logic link_ok = arg_q[0] == `BPC_LINK_31 || arg_q[0] == `BPC_LINK_37
		|| arg_q[0] == `BPC_LINK_TEST || arg_q[0] == `BPC_LINK_255;
	wire logic tail_bad = |{arg_q[4], arg_q[5], arg_q[6]}; // [RL10]
	// Frame settings only take hold once BLE framing has been chosen
	wire logic frame_apply = cmd_frame && fmt_ble_q && link_ok; // [RL3]
	wire logic err_d = (go_ok && !cmd_known)
		|| (cmd_idle && arg_q[0] != `BPC_STBY_RC)
		|| (cmd_frame && (!fmt_ble_q || !link_ok || tail_bad));

	// Carrier word times reference, divided by two to the eighteenth
	wire logic [49:0] hz_prod = 50'(carrier_q) * `BPC_FREF_HZ; // [RL4]

	// Controller
	always_comb begin
		state_d = state_q;
		case (state_q)
			BPC_ST_CAL: begin
				if (cal_cnt_q == 20'h0) begin
					state_d = BPC_ST_IDLE; // [RL1]
				end
			end
			BPC_ST_IDLE: begin
				if (go_ok) begin
					state_d = BPC_ST_EXEC;
				end
			end
			BPC_ST_EXEC: begin
				if (exec_cnt_q == 3'h0) begin
					state_d = BPC_ST_IDLE;
				end
			end
			default: state_d = BPC_ST_CAL;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= BPC_ST_CAL;
			cal_cnt_q  <= 20'(CAL_CYCLES - 1);
			exec_cnt_q <= 3'h0;
			busy_q     <= 1'b1;
		end else begin
			state_q <= state_d;
			busy_q  <= state_d != BPC_ST_IDLE; // [RL1] [RL21]
			if (state_q == BPC_ST_CAL && cal_cnt_q != 20'h0) begin
				cal_cnt_q <= cal_cnt_q - 20'h1;
			end
			if (go_ok) begin
				exec_cnt_q <= `BPC_CMD_CYCLES - 3'h1;
			end else if (exec_cnt_q != 3'h0) begin
				exec_cnt_q <= exec_cnt_q - 3'h1;
			end
		end
	end

	// Staging and byte locations
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			opc_q <= 8'h00;
		end else if (reg_wr && hit_opc) begin
			opc_q <= reg_wdata[7:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_arg
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					arg_q[gi] <= 8'h00;
				end else if (reg_wr && hit_arg && arg_sel == 3'(gi)) begin
					arg_q[gi] <= reg_wdata[7:0];
				end
			end
		end
		for (gi = 0; gi < `BPC_CFG_BYTES; gi++) begin : g_cfg
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					cfg_q[gi] <= 8'h00;
				end else if (reg_wr && hit_cfg && cfg_sel == 3'(gi)) begin
					cfg_q[gi] <= reg_wdata[7:0]; // [RL19] [RL20]
				end
			end
		end
	endgenerate

	// Command effects
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fmt_ble_q <= 1'b0;
			err_q     <= 1'b0;
			carrier_q <= 24'h000000;
			tx_off_q  <= 8'h00;
			rx_off_q  <= 8'h00;
		end else begin
			if (go_ok) begin
				err_q <= err_d;
			end
			if (cmd_fmt) begin
				fmt_ble_q <= arg_q[0] == `BPC_FMT_BLE; // [RL3]
			end
			if (cmd_carrier) begin
				carrier_q <= {arg_q[0], arg_q[1], arg_q[2]}; // [RL5]
			end
			if (cmd_offsets) begin
				tx_off_q <= arg_q[0]; // [RL6]
				rx_off_q <= arg_q[1];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rate_q    <= `BPC_RATE_1M_BW_1P2;
			index_q   <= `BPC_MOD_INDEX_HALF;
			shaping_q <= `BPC_SHAPING_BT_HALF;
			link_q    <= `BPC_LINK_31;
			check_q   <= `BPC_CHECK_3B;
			pat_q     <= `BPC_PAT_PRBS9;
			wht_q     <= `BPC_SCRAMBLER_ON;
		end else begin
			if (cmd_modem) begin
				rate_q    <= arg_q[0]; // [RL7]
				index_q   <= arg_q[1];
				shaping_q <= arg_q[2];
			end
			if (frame_apply) begin
				link_q  <= arg_q[0];
				check_q <= arg_q[1];
				pat_q   <= arg_q[2];
				wht_q   <= arg_q[3];
			end
		end
	end

	// Payload pointers and synthesizer output
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ptr_q <= 8'h00;
			rx_ptr_q <= 8'h00;
			hz_q     <= 32'h0;
		end else begin
			hz_q <= hz_prod[`BPC_PLL_DIV_BITS +: 32]; // [RL4] [RL5]
			if (pkt_start) begin
				tx_ptr_q <= tx_off_q; // [RL6]
				rx_ptr_q <= rx_off_q;
			end else begin
				tx_ptr_q <= tx_ptr_q + 8'(tx_byte_take);
				rx_ptr_q <= rx_ptr_q + 8'(rx_byte_put);
			end
		end
	end

	// Derived configuration
	wire logic [7:0] max_len =
		(link_q == `BPC_LINK_37)   ? `BPC_LEN_37  :
		(link_q == `BPC_LINK_TEST) ? `BPC_LEN_63  :
		(link_q == `BPC_LINK_255)  ? `BPC_LEN_255 : `BPC_LEN_31; // [RL11]
	wire logic test_state = link_q == `BPC_LINK_TEST;

	assign modem_cfg.rate            = rate_q;
	assign modem_cfg.index           = index_q;
	assign modem_cfg.shaping         = shaping_q;
	assign modem_cfg.rate_1m_bw_1p2  = rate_q == `BPC_RATE_1M_BW_1P2; // [RL7]
	assign modem_cfg.mod_index_half  = index_q == `BPC_MOD_INDEX_HALF; // [RL8]
	assign modem_cfg.shaping_bt_half = shaping_q == `BPC_SHAPING_BT_HALF; // [RL9]
	assign frame_cfg.max_payload         = max_len;
	assign frame_cfg.check_three_bytes   = check_q == `BPC_CHECK_3B; // [RL12]
	// Unknown codes leave whitening on, the safe default on air
	assign frame_cfg.scrambler_on        = wht_q != `BPC_SCRAMBLER_OFF; // [RL17]
	assign frame_cfg.transmit_test_state = test_state;
	assign frame_cfg.test_pattern_select = pat_q;

	bpc_pattern_gen u_pattern (
		.core_clk    (core_clk),
		.rst_b       (rst_b),
		.enable      (test_state && fmt_ble_q), // [RL16]
		.pattern_sel (pat_q),
		.restart     (pkt_start),
		.bit_take    (test_bit_take),
		.test_bit    (test_bit)
	);

	// Read path
	wire logic [31:0] stat_word = {27'h0, state_q == BPC_ST_CAL, err_q, fmt_ble_q,
		state_q != BPC_ST_CAL, busy_q};
	wire logic [31:0] rd_mux =
		hit_opc ? {24'h0, opc_q} :
		hit_arg ? {24'h0, arg_q[arg_sel]} :
		hit_cfg ? {24'h0, cfg_q[cfg_sel]} :
		reg_addr == `BPC_OFS_STATUS  ? stat_word :
		reg_addr == `BPC_OFS_CARRIER ? {8'h0, carrier_q} :
		reg_addr == `BPC_OFS_OFFSETS ? {16'h0, rx_off_q, tx_off_q} :
		reg_addr == `BPC_OFS_MODEM   ? {8'h0, rate_q, index_q, shaping_q} :
		reg_addr == `BPC_OFS_FRAME   ? {link_q, check_q, pat_q, wht_q} :
		reg_addr == `BPC_OFS_RATE_HZ ? hz_q : 32'h0;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 32'h0;
		end
	end

	assign reg_rdata               = rdata_q;
	assign busy                    = busy_q;
	assign rc_oscillator_standby   = state_q != BPC_ST_CAL;
	assign frame_format_ble        = fmt_ble_q;
	assign carrier_word            = carrier_q;
	assign carrier_hz              = hz_q;
	assign transmit_payload_offset = tx_off_q;
	assign receive_payload_offset  = rx_off_q;
	assign access_addr             = {cfg_q[0], cfg_q[1], cfg_q[2], cfg_q[3]}; // [RL19]
	assign check_seed              = {cfg_q[4], cfg_q[5], cfg_q[6]}; // [RL20]
	assign cmd_error               = err_q;
	assign tx_buf_addr             = tx_ptr_q;
	assign rx_buf_addr             = rx_ptr_q;

	// Checks
	property p_cal_hold;
		@(posedge core_clk) disable iff (!rst_b)
		(state_q == BPC_ST_CAL && cal_cnt_q != 20'h0) |=> busy && state_q == BPC_ST_CAL;
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("calibration ended early"); // [RL1]

	property p_cal_done;
		@(posedge core_clk) disable iff (!rst_b)
		(state_q == BPC_ST_CAL && cal_cnt_q == 20'h0) |=> !busy && rc_oscillator_standby;
	endproperty
	a_cal_done: assert property (p_cal_done) else $error("busy not low after calibration"); // [RL1]

	property p_cmd_busy;
		@(posedge core_clk) disable iff (!rst_b)
		go_ok |=> busy[*4] ##1 !busy;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy) else $error("busy window wrong"); // [RL21]

	property p_fmt;
		@(posedge core_clk) disable iff (!rst_b)
		(cmd_fmt && arg_q[0] == `BPC_FMT_BLE) |=> frame_format_ble;
	endproperty
	a_fmt: assert property (p_fmt) else $error("BLE format not taken"); // [RL3]

	property p_carrier;
		@(posedge core_clk) disable iff (!rst_b)
		cmd_carrier |=> carrier_word == {$past(arg_q[0]), $past(arg_q[1]), $past(arg_q[2])};
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier word wrong"); // [RL5]

	property p_step;
		@(posedge core_clk) disable iff (!rst_b)
		(carrier_word == 24'h040000) [*2] |-> carrier_hz == 32'd52000000;
	endproperty
	a_step: assert property (p_step) else $error("synthesizer step wrong"); // [RL4]

	property p_ptr;
		@(posedge core_clk) disable iff (!rst_b)
		pkt_start |=> tx_buf_addr == $past(tx_off_q) && rx_buf_addr == $past(rx_off_q);
	endproperty
	a_ptr: assert property (p_ptr) else $error("payload pointer not at offset"); // [RL6]

	property p_modem;
		@(posedge core_clk) disable iff (!rst_b)
		(cmd_modem && arg_q[1] == `BPC_MOD_INDEX_HALF && arg_q[2] == `BPC_SHAPING_BT_HALF)
		|=> modem_cfg.mod_index_half && modem_cfg.shaping_bt_half;
	endproperty
	a_modem: assert property (p_modem) else $error("modem decode wrong"); // [RL8] [RL9]

	property p_len255;
		@(posedge core_clk) disable iff (!rst_b)
		(frame_apply && arg_q[0] == `BPC_LINK_255) |=> frame_cfg.max_payload == 8'd255;
	endproperty
	a_len255: assert property (p_len255) else $error("max payload wrong"); // [RL11]

	property p_check;
		@(posedge core_clk) disable iff (!rst_b)
		(frame_apply && arg_q[1] == `BPC_CHECK_OFF && arg_q[3] == `BPC_SCRAMBLER_OFF)
		|=> !frame_cfg.check_three_bytes && !frame_cfg.scrambler_on;
	endproperty
	a_check: assert property (p_check) else $error("check or whitening wrong"); // [RL12] [RL17]

	property p_ignore;
		@(posedge core_clk) disable iff (!rst_b)
		!frame_cfg.transmit_test_state |-> !test_bit;
	endproperty
	a_ignore: assert property (p_ignore) else $error("test bits outside test state"); // [RL16]

	property p_tail;
		@(posedge core_clk) disable iff (!rst_b)
		(cmd_frame && tail_bad) |=> cmd_error;
	endproperty
	a_tail: assert property (p_tail) else $error("nonzero tail not flagged"); // [RL10]

	c_cal_done: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(busy));
	c_frame: cover property (@(posedge core_clk) disable iff (!rst_b) frame_apply);
	c_test: cover property (@(posedge core_clk) disable iff (!rst_b)
		frame_cfg.transmit_test_state && test_bit_take);

endmodule // bpc_cmd_core

// file: bench/bpc_host_model.sv
// Host controller model driving the command register port
`include "bpc_regs.svh"
module bpc_host_model (
	// Clock and busy pin
	input  wire logic        core_clk,
	input  wire logic        busy,
	// Register port
	output logic      [15:0] reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 16'h0000;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Bounded wait, so a stuck busy pin cannot hang the host
	task automatic cmd(input logic [7:0] opc, input logic [55:0] args);
		int n;
		n = 0;
		#1;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge core_clk);
			#1 n++;
		end
		wr(`BPC_OFS_OPC, {24'h0, opc});
		for (int i = 0; i < 7; i++) begin
			wr(`BPC_OFS_ARG0 + 16'(4 * i), {24'h0, args[55 - 8 * i -: 8]});
		end
		wr(`BPC_OFS_GO, 32'h0);
	endtask
endmodule // bpc_host_model

// file: bench/test_bpc_cmd_core.sv
// Self-checking bench for the command interpreter
module test_bpc_cmd_core import bpc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_b, reg_wr, reg_rd, busy, rc_oscillator_standby, frame_format_ble;
	logic cmd_error, pkt_start, tx_byte_take, rx_byte_put, test_bit_take, test_bit;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, carrier_hz, access_addr, d;
	logic [23:0] carrier_word, check_seed, w;
	logic [7:0] transmit_payload_offset, receive_payload_offset, tx_buf_addr, rx_buf_addr;
	logic [7:0] tx, rx;
	bpc_modem_cfg_t modem_cfg;
	bpc_frame_cfg_t frame_cfg;
	integer seed, num_errors, n_checks, cycles;
	bpc_cmd_core #(.CAL_CYCLES(20)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .busy(busy), .rc_oscillator_standby(rc_oscillator_standby),
		.frame_format_ble(frame_format_ble), .carrier_word(carrier_word),
		.carrier_hz(carrier_hz), .transmit_payload_offset(transmit_payload_offset),
		.receive_payload_offset(receive_payload_offset), .modem_cfg(modem_cfg),
		.frame_cfg(frame_cfg), .access_addr(access_addr), .check_seed(check_seed),
		.cmd_error(cmd_error), .pkt_start(pkt_start), .tx_byte_take(tx_byte_take),
		.rx_byte_put(rx_byte_put), .test_bit_take(test_bit_take),
		.tx_buf_addr(tx_buf_addr), .rx_buf_addr(rx_buf_addr), .test_bit(test_bit));
	bpc_host_model h (.core_clk(core_clk), .busy(busy), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			$display("BAD %0t %s", $time, m);
			num_errors++;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic settle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 10) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk({31'h0, busy}, 32'h0, "busy stuck");
	endtask
	task automatic run(input logic [7:0] opc, input logic [55:0] args);
		h.cmd(opc, args);
		#1 chk({31'h0, busy}, 32'h1, "busy after go");
		settle;
	endtask
	// Pattern bits are compared from the first bit after a packet start
	task automatic pat(input logic [7:0] p, input logic [7:0] link);
		logic [8:0] s9;
		logic [14:0] s15;
		logic [7:0] b;
		logic e;
		s9 = 9'h1ff;
		s15 = 15'h7fff;
		b = p == 8'h04 ? 8'hf0 : p == 8'h08 ? 8'haa : p == 8'h18 ? 8'h0f : 8'h55;
		if (p == 8'h10 || p == 8'h14) b = 8'hff;
		run(8'h06, {link, 8'h10, p, link == 8'h40 ? 8'h08 : 8'h00, 24'h0});
		chk({24'h0, frame_cfg.test_pattern_select}, {24'h0, p}, "pattern select");
		@(posedge core_clk) pkt_start <= 1'b1;
		@(posedge core_clk) pkt_start <= 1'b0;
		test_bit_take <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			#1 e = b[7 - i % 8];
			if (p == 8'h00) e = s9[8];
			if (p == 8'h0c) e = s15[14];
			s9 = {s9[7:0], s9[8] ^ s9[4]};
			s15 = {s15[13:0], ^{s15[14:11], s15[1:0]}};
			chk({31'h0, test_bit}, {31'h0, e & link[6]}, "test bit");
			@(posedge core_clk);
		end
		test_bit_take <= 1'b0;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict;
		end
	end
	initial begin
		{num_errors, n_checks, cycles} = 0;
		seed = 32'hffab14ec;
		{rst_b, pkt_start, tx_byte_take, rx_byte_put, test_bit_take} = 5'h0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		#1 chk({31'h0, busy}, 32'h1, "busy in calibration");
		repeat (19) @(posedge core_clk);
		#1 chk({31'h0, busy}, 32'h1, "calibration too short");
		settle;
		chk({31'h0, rc_oscillator_standby}, 32'h1, "standby");
		h.rd(16'h0100, d);
		chk(d, 32'h0, "unmapped read");
		run(8'h01, 56'h0);
		chk({31'h0, cmd_error}, 32'h0, "standby error");
		run(8'h09, 56'h0);
		chk({31'h0, cmd_error}, 32'h1, "unknown opcode");
		run(8'h02, {8'h04, 48'h0});
		chk({31'h0, frame_format_ble}, 32'h1, "ble format");
		$display("test setup done");
		for (int k = 0; k < 2; k++) begin
			w = k ? 24'h040000 : 24'($random(seed));
			run(8'h03, {w, 32'h0});
			chk(carrier_word, w, "carrier word");
			chk(carrier_hz, 32'((64'(w) * 64'd52000000) >> 18), "carrier hz");
			h.rd(16'h0028, d);
			chk(d, {8'h0, w}, "carrier read");
		end
		{tx, rx} = 16'($random(seed));
		run(8'h04, {tx, rx, 40'h0});
		chk({transmit_payload_offset, receive_payload_offset}, {tx, rx}, "offsets");
		@(posedge core_clk) pkt_start <= 1'b1;
		@(posedge core_clk) pkt_start <= 1'b0;
		{tx_byte_take, rx_byte_put} <= 2'b11;
		#1 chk({tx_buf_addr, rx_buf_addr}, {tx, rx}, "buffer start");
		@(posedge core_clk) {tx_byte_take, rx_byte_put} <= 2'b00;
		#1 chk({tx_buf_addr, rx_buf_addr}, {tx + 8'h1, rx + 8'h1}, "buffer step");
		for (int k = 0; k < 2; k++) begin
			run(8'h05, {k ? 24'h450120 : 24'h440210, 32'h0});
			chk({modem_cfg.rate_1m_bw_1p2, modem_cfg.mod_index_half, modem_cfg.shaping_bt_half},
				k ? 32'h7 : 32'h0, "modem flags");
			chk({modem_cfg.rate, modem_cfg.index, modem_cfg.shaping}, k ? 24'h450120 : 24'h440210,
				"modem bytes");
		end
		for (int i = 0; i < 4; i++) begin
			run(8'h06, {8'(i < 3 ? 32 * i : 128), i[0] ? 8'h10 : 8'h00, 8'h00,
				i == 2 ? 8'h08 : 8'h00, 24'h0});
			chk({frame_cfg.max_payload, frame_cfg.check_three_bytes, frame_cfg.scrambler_on,
				frame_cfg.transmit_test_state}, {8'(i == 0 ? 31 : i == 1 ? 37 : i == 2 ? 63 : 255),
				i[0], i != 2, i == 2}, "frame config");
		end
		run(8'h06, {8'h00, 8'h10, 8'h00, 8'h00, 24'h000001});
		chk({31'h0, cmd_error}, 32'h1, "nonzero tail");
		$display("test config done");
		for (int k = 0; k < 8; k++) pat(8'(4 * k), 8'h40);
		pat(8'h08, 8'h00);
		$display("test patterns done");
		w = 24'($random(seed));
		d = $random(seed);
		for (int i = 0; i < 4; i++) h.wr(16'h273c + 16'(4 * i), {24'h0, d[31 - 8 * i -: 8]});
		for (int i = 0; i < 3; i++) h.wr(16'h271c + 16'(4 * i), {24'h0, w[23 - 8 * i -: 8]});
		#1 chk(access_addr, d, "access address");
		chk({8'h0, check_seed}, {8'h0, w}, "check seed");
		$display("test byte locations done");
		print_verdict;
	end
endmodule // test_bpc_cmd_core
